/* design/snc_regs.vh */
`ifndef SNC_REGS_VH
`define SNC_REGS_VH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define SNC_OFS_CONTROL  8'h00
`define SNC_OFS_STATUS   8'h04

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define SNC_CTL_RA       31
`define SNC_CTL_RX       30
`define SNC_CTL_RC       29
`define SNC_CTL_RD       17
`define SNC_CTL_RE       16
`define SNC_CTL_TR       11
`define SNC_CTL_TT       10
`define SNC_CTL_LI       9
`define SNC_CTL_TQ       8
`define SNC_CTL_RS       6
`define SNC_CTL_OPM      5
`define SNC_CTL_TI       4
`define SNC_CTL_IE       3
`define SNC_CTL_AS       2
`define SNC_CTL_LS       1
`define SNC_CTL_LD       0

// ---------------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------------
`define SNC_STS_LS_HI    23
`define SNC_STS_LS_LO    21
`define SNC_STS_EE       8
`define SNC_STS_IA       7
`define SNC_STS_WE       6

// ---------------------------------------------------------------------------
// Reset values and link states
// ---------------------------------------------------------------------------
`define SNC_RST_LINK_LAUNCH 1'b1
`define SNC_LST_ERR_RESET   3'h0
`define SNC_LST_ERR_WAIT    3'h1
`define SNC_LST_READY       3'h2
`define SNC_LST_STARTED     3'h3
`define SNC_LST_CONNECTING  3'h4
`define SNC_LST_RUN         3'h5

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define SNC_CLK_NS          100
`define SNC_SOFT_RESET_NS   200
`define SNC_SOFT_RESET_CYC  ((`SNC_SOFT_RESET_NS + `SNC_CLK_NS - 1) / `SNC_CLK_NS)

`endif

/* design/snc_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of levels from outside the clock domain.
module snc_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clock,
    input  wire         reset,
    // Levels
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] stage1;

    always @(posedge clock) begin
        if (reset) begin
            stage1   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // snc_sync

/* design/snc_node_regs.v */
`timescale 1ns/1ps
// Functional notes
// RQ1: Remote-access available bit reads 0 on instances 0,1 and 1 on 2,3.
// RQ2: Receiver unaligned-write capability bit always reads 0, writes ignored.
// RQ3: Remote checksum support bit reads 0 on instances 0,1, 1 on 2,3.
// RQ4: Single-buffer bit makes remote handler use one buffer; resets to 0.
// RQ5: Remote handler runs only while the handler-enable bit is 1.
// RQ6: Incoming time-codes accepted only while the accept bit is set; resets 0.
// RQ7: Time-codes transmitted only while the send bit is set; resets 0.
// RQ8: Link-error interrupt enable raises interrupt on link errors; not reset.
// RQ9: Time-code arrival interrupt enable raises interrupt on valid time-codes; not reset.
// RQ10: Writing 1 to soft-clear resets the whole node, then self-clears.
// RQ11: Open-packet mode bit selects open-packet or normal mode; resets 0.
// RQ12: Writing 1 to tick-in increments time counter and sends it after current char; the code ignores it while the send bit is 0.
// RQ13: Global gate enables interrupts from enabled events in bits 8-9; resets 0.
// RQ14: Autostart starts the link after a NULL from the remote end; not reset.
// RQ15: Link-launch lets the link go from ready to started; resets to 1.
// RQ16: Writing 1 to codec-shutoff disables the codec; writing 0 does nothing.
// RQ17: Early-end flag set on early EOP; write 1 clears; resets 0.
// RQ18: Bad-destination flag set on invalid address; write 1 clears; resets 0.
// RQ19: Write-sync flag set on N-Char sync problem; write 1 clears; resets 0.
// RQ20: Status bits 23:21 report the link start-up state, codes 0 to 5.
// RQ21: Reserved bits read zero and ignore writes.
`include "snc_regs.vh"

module snc_node_regs #(
    parameter [1:0] INSTANCE = 2'd0
) (
    // Clock and reset
    input  wire        clock,
    input  wire        reset,
    // Register port
    input  wire        reg_sel,
    input  wire        reg_write,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata,
    // Codec events, asynchronous to clock
    input  wire        null_received,
    input  wire        early_end_event,
    input  wire        bad_destination_event,
    input  wire        write_sync_event,
    input  wire        link_error_event,
    input  wire        timecode_valid_event,
    input  wire        char_done,
    // Link clock, sampled
    input  wire        link_clock,
    // Control outputs
    output reg         remote_handler_on,
    output reg         remote_single_buffer,
    output reg         timecode_accept_on,
    output reg         timecode_send_on,
    output reg         open_packet_mode,
    output reg         codec_shutoff,
    output reg         node_soft_clear,
    output reg         timecode_send_pulse,
    output reg  [5:0]  time_counter,
    output reg  [2:0]  link_state,
    output reg         link_clock_edge,
    output reg         irq
);
    // -----------------------------------------------------------------------
    // Synchronised inputs
    // -----------------------------------------------------------------------
    // -----------------------------------------------------------------------
    // Constants
    // -----------------------------------------------------------------------
    // Soft reset counter load in clock cycles, cut to the width of its counter; the clear lasts one cycle more.
    localparam [31:0] SOFT_CYC = `SNC_SOFT_RESET_CYC;

    // -----------------------------------------------------------------------
    // Edge detection on synchronised levels
    // -----------------------------------------------------------------------
    // The previous sample is loaded with the current one during any reset,
    // so a level already high at the end of a soft clear does not look like a fresh edge.
    wire [7:0] ev_sync;
    reg  [7:0] ev_prev;
    wire [7:0] ev_rise = ev_sync & ~ev_prev;

    snc_sync #(.W(8)) u_sync (
        .clock    (clock),
        .reset    (reset),
        .async_in ({link_clock, char_done, timecode_valid_event, link_error_event,
                    write_sync_event, bad_destination_event, early_end_event, null_received}),
        .sync_out (ev_sync)
    );

    wire null_rise   = ev_rise[0];
    wire ee_rise     = ev_rise[1];
    wire ia_rise     = ev_rise[2];
    wire we_rise     = ev_rise[3];
    wire lerr_rise   = ev_rise[4];
    wire tcv_rise    = ev_rise[5];
    wire chdone_rise = ev_rise[6];
    wire lclk_rise   = ev_rise[7];

    // -----------------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------------
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    wire wr_ctl = reg_sel && reg_write && hit(reg_addr, `SNC_OFS_CONTROL);
    wire wr_sts = reg_sel && reg_write && hit(reg_addr, `SNC_OFS_STATUS);
    wire cap_hi = INSTANCE[1];

    // -----------------------------------------------------------------------
    // Control bits
    // -----------------------------------------------------------------------
    reg        connection_fault_irq_on;
    reg        timecode_arrival_irq_on;
    reg        auto_link_launch;
    reg        global_irq_gate;
    reg        link_launch;
    reg        tick_pending;
    reg        early_packet_end_error;
    reg        bad_destination_error;
    reg        write_sync_error;
    reg  [1:0] soft_cnt;
    wire       node_rst = reset || node_soft_clear;

    // Bits that are not reset keep their value across both resets.
    always @(posedge clock) begin
        if (wr_ctl) begin
            connection_fault_irq_on <= reg_wdata[`SNC_CTL_LI]; // RQ8
            timecode_arrival_irq_on <= reg_wdata[`SNC_CTL_TQ]; // RQ9
            auto_link_launch        <= reg_wdata[`SNC_CTL_AS]; // RQ14
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            node_soft_clear <= 1'b0;
            soft_cnt        <= 2'd0;
        end else if (wr_ctl && reg_wdata[`SNC_CTL_RS]) begin
            node_soft_clear <= 1'b1; // RQ10
            soft_cnt        <= SOFT_CYC[1:0];
        end else if (soft_cnt != 2'd0) begin
            soft_cnt        <= soft_cnt - 2'd1;
        end else begin
            node_soft_clear <= 1'b0; // RQ10
        end
    end

    always @(posedge clock) begin
        if (node_rst) begin
            remote_single_buffer <= 1'b0;
            remote_handler_on    <= 1'b0;
            timecode_accept_on   <= 1'b0;
            timecode_send_on     <= 1'b0;
            open_packet_mode     <= 1'b0;
            global_irq_gate      <= 1'b0;
            link_launch          <= `SNC_RST_LINK_LAUNCH;
            codec_shutoff        <= 1'b0;
        end else if (wr_ctl) begin
            remote_single_buffer <= reg_wdata[`SNC_CTL_RD]; // RQ4
            remote_handler_on    <= reg_wdata[`SNC_CTL_RE]; // RQ5
            timecode_accept_on   <= reg_wdata[`SNC_CTL_TR]; // RQ6
            timecode_send_on     <= reg_wdata[`SNC_CTL_TT]; // RQ7
            open_packet_mode     <= reg_wdata[`SNC_CTL_OPM]; // RQ11
            global_irq_gate      <= reg_wdata[`SNC_CTL_IE]; // RQ13
            link_launch          <= reg_wdata[`SNC_CTL_LS]; // RQ15
            if (reg_wdata[`SNC_CTL_LD])
                codec_shutoff    <= 1'b1; // RQ16
        end
    end

    // -----------------------------------------------------------------------
    // Tick-in and time counter
    // -----------------------------------------------------------------------
    always @(posedge clock) begin
        if (node_rst) begin
            tick_pending        <= 1'b0;
            time_counter        <= 6'h00;
            timecode_send_pulse <= 1'b0;
        end else begin
            timecode_send_pulse <= 1'b0;
            if (wr_ctl && reg_wdata[`SNC_CTL_TI] && timecode_send_on) begin
                time_counter <= time_counter + 6'h01; // RQ12
                tick_pending <= 1'b1;
            end else if (tick_pending && chdone_rise) begin
                // A pending tick is dropped silently if sending was
                // switched off before the current character finished.
                tick_pending        <= 1'b0; // RQ12
                timecode_send_pulse <= timecode_send_on; // RQ7
            end
        end
    end

    // -----------------------------------------------------------------------
    // Sticky error flags; a set wins over a clear in the same cycle
    // -----------------------------------------------------------------------
    always @(posedge clock) begin
        if (node_rst) begin
            early_packet_end_error <= 1'b0;
            bad_destination_error  <= 1'b0;
            write_sync_error       <= 1'b0;
        end else begin
            if (ee_rise)
                early_packet_end_error <= 1'b1; // RQ17
            else if (wr_sts && reg_wdata[`SNC_STS_EE])
                early_packet_end_error <= 1'b0; // RQ17
            if (ia_rise)
                bad_destination_error <= 1'b1; // RQ18
            else if (wr_sts && reg_wdata[`SNC_STS_IA])
                bad_destination_error <= 1'b0; // RQ18
            if (we_rise)
                write_sync_error <= 1'b1; // RQ19
            else if (wr_sts && reg_wdata[`SNC_STS_WE])
                write_sync_error <= 1'b0; // RQ19
        end
    end

    // -----------------------------------------------------------------------
    // Link start-up state
    // -----------------------------------------------------------------------
    reg [2:0] next_link_state;
    wire      may_start = link_launch || (auto_link_launch && null_rise);

    always @* begin
        next_link_state = link_state;
        case (link_state)
            `SNC_LST_ERR_RESET:  next_link_state = `SNC_LST_ERR_WAIT;
            `SNC_LST_ERR_WAIT:   next_link_state = `SNC_LST_READY;
            `SNC_LST_READY:      if (may_start) next_link_state = `SNC_LST_STARTED; // RQ15 RQ14
            `SNC_LST_STARTED:    if (null_rise) next_link_state = `SNC_LST_CONNECTING;
            `SNC_LST_CONNECTING: if (lclk_rise) next_link_state = `SNC_LST_RUN;
            `SNC_LST_RUN:        next_link_state = `SNC_LST_RUN;
            default:             next_link_state = `SNC_LST_ERR_RESET;
        endcase
        if (codec_shutoff || lerr_rise)
            next_link_state = `SNC_LST_ERR_RESET; // RQ16
    end

    always @(posedge clock) begin
        if (node_rst) begin
            link_state      <= `SNC_LST_ERR_RESET;
            ev_prev         <= ev_sync;
            link_clock_edge <= 1'b0;
        end else begin
            link_state      <= next_link_state; // RQ20
            ev_prev         <= ev_sync;
            link_clock_edge <= lclk_rise;
        end
    end

    // -----------------------------------------------------------------------
    // Interrupt
    // -----------------------------------------------------------------------
    always @(posedge clock) begin
        if (node_rst)
            irq <= 1'b0;
        else
            irq <= global_irq_gate &&
                   ((connection_fault_irq_on && lerr_rise) ||
                    (timecode_arrival_irq_on && timecode_accept_on && tcv_rise)); // RQ13 RQ8 RQ9 RQ6
    end

    // -----------------------------------------------------------------------
    // Read data; reserved bits are zero
    // -----------------------------------------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000; // RQ21
            if (reg_sel && !reg_write && hit(reg_addr, `SNC_OFS_CONTROL)) begin
                reg_rdata[`SNC_CTL_RA]  <= cap_hi; // RQ1
                reg_rdata[`SNC_CTL_RX]  <= 1'b0; // RQ2
                reg_rdata[`SNC_CTL_RC]  <= cap_hi; // RQ3
                reg_rdata[`SNC_CTL_RD]  <= remote_single_buffer;
                reg_rdata[`SNC_CTL_RE]  <= remote_handler_on;
                reg_rdata[`SNC_CTL_TR]  <= timecode_accept_on;
                reg_rdata[`SNC_CTL_TT]  <= timecode_send_on;
                reg_rdata[`SNC_CTL_LI]  <= connection_fault_irq_on;
                reg_rdata[`SNC_CTL_TQ]  <= timecode_arrival_irq_on;
                reg_rdata[`SNC_CTL_OPM] <= open_packet_mode;
                reg_rdata[`SNC_CTL_IE]  <= global_irq_gate;
                reg_rdata[`SNC_CTL_AS]  <= auto_link_launch;
                reg_rdata[`SNC_CTL_LS]  <= link_launch;
                reg_rdata[`SNC_CTL_LD]  <= codec_shutoff;
            end else if (reg_sel && !reg_write && hit(reg_addr, `SNC_OFS_STATUS)) begin
                reg_rdata[`SNC_STS_LS_HI:`SNC_STS_LS_LO] <= link_state; // RQ20
                reg_rdata[`SNC_STS_EE] <= early_packet_end_error;
                reg_rdata[`SNC_STS_IA] <= bad_destination_error;
                reg_rdata[`SNC_STS_WE] <= write_sync_error;
            end
        end
    end
endmodule // snc_node_regs

/* verification/snc_node_regs_assertions.sv */
`timescale 1ns/1ps
`include "snc_regs.vh"
module snc_node_regs_chk #(
    parameter [1:0] INSTANCE = 2'd0
) (
    // Clock, reset and register port
    input wire clock, input wire reset, input wire reg_sel, input wire reg_write,
    input wire [7:0] reg_addr, input wire [31:0] reg_wdata, input wire [31:0] reg_rdata,
    // Control and status outputs
    input wire remote_handler_on, input wire remote_single_buffer, input wire timecode_accept_on,
    input wire timecode_send_on, input wire open_packet_mode, input wire codec_shutoff,
    input wire node_soft_clear, input wire timecode_send_pulse, input wire [5:0] time_counter,
    input wire [2:0] link_state, input wire irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire rd_ctl = reg_sel && !reg_write && reg_addr == `SNC_OFS_CONTROL;
    wire rd_sts = reg_sel && !reg_write && reg_addr == `SNC_OFS_STATUS;
    wire wr_ctl = reg_sel && reg_write && reg_addr == `SNC_OFS_CONTROL;
    wire cap    = INSTANCE >= 2'd2;
    AST_RDATA_IDLE: assert property (!$past(reg_sel && !reg_write) |-> reg_rdata == 32'h0)
        else $error("read data not idle");
    AST_CAP_RA_RC: assert property (rd_ctl |=> reg_rdata[31] == cap && reg_rdata[29] == cap)
        else $error("capability bits wrong");
    AST_CAP_RX: assert property (rd_ctl |=> !reg_rdata[30])
        else $error("unaligned capability set");
    AST_CTL_RSVD: assert property (rd_ctl |=> reg_rdata[28:18] == 11'h0 && reg_rdata[15:12] == 4'h0 && !reg_rdata[7])
        else $error("control reserved bits set");
    AST_STS_FIELD: assert property (rd_sts |=> reg_rdata[23:21] == $past(link_state) && reg_rdata[31:24] == 8'h0 && reg_rdata[20:9] == 12'h0)
        else $error("status field wrong");
    AST_LINK_CODE: assert property (link_state <= 3'h5)
        else $error("link state code out of range");
    AST_CTL_WRITE: assert property (wr_ctl && !reg_wdata[6] && !node_soft_clear |=> {remote_single_buffer, remote_handler_on, timecode_accept_on, timecode_send_on, open_packet_mode} == {$past(reg_wdata[17:16]), $past(reg_wdata[11:10]), $past(reg_wdata[5])})
        else $error("control levels do not follow write");
    AST_SHUTOFF_SET: assert property (wr_ctl && reg_wdata[0] |=> codec_shutoff)
        else $error("codec not shut off");
    AST_SHUTOFF_HOLD: assert property (codec_shutoff && !node_soft_clear && !$past(node_soft_clear) && !(wr_ctl && reg_wdata[6]) |=> codec_shutoff)
        else $error("codec shutoff dropped");
    AST_SHUTOFF_LINK: assert property (codec_shutoff |=> link_state == 3'h0)
        else $error("link not held in reset");
    AST_SOFT_CLEAR: assert property (wr_ctl && reg_wdata[6] |=> node_soft_clear [*3] ##1 !node_soft_clear)
        else $error("soft clear length wrong");
    AST_TICK: assert property (wr_ctl && reg_wdata[4] && !reg_wdata[6] |=> time_counter == $past(time_counter) + {5'h0, $past(timecode_send_on)})
        else $error("tick count wrong");
    AST_SEND_GATE: assert property (timecode_send_pulse |-> timecode_send_on || $past(timecode_send_on))
        else $error("time code sent while disabled");
    cover property (wr_ctl && reg_wdata[6]);
    cover property (link_state == 3'h5);
    cover property (irq);
    cover property (timecode_send_pulse);
endmodule // snc_node_regs_chk
bind snc_node_regs snc_node_regs_chk #(.INSTANCE(INSTANCE)) u_chk (.clock(clock), .reset(reset),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .remote_handler_on(remote_handler_on), .remote_single_buffer(remote_single_buffer),
    .timecode_accept_on(timecode_accept_on), .timecode_send_on(timecode_send_on),
    .open_packet_mode(open_packet_mode), .codec_shutoff(codec_shutoff), .node_soft_clear(node_soft_clear),
    .timecode_send_pulse(timecode_send_pulse), .time_counter(time_counter), .link_state(link_state), .irq(irq));

/* verification/snc_far_node.sv */
`timescale 1ns/1ps
module snc_far_node (
    // Link activity request
    input  wire       run,
    // Event levels and link clock toward the node
    output reg  [6:0] ev,
    output reg        link_clock
);
    // The link clock toggles only while run is high and rests low otherwise.
    initial begin
        ev = 7'h0;
        link_clock = 1'b0;
        #37;
        forever begin
            #400;
            link_clock = run ? ~link_clock : 1'b0;
        end
    end
    // An event is a level held long enough for the node's two-flop sampler.
    task pulse(input integer i);
        begin
            ev[i] = 1'b1;
            #500;
            ev[i] = 1'b0;
            #500;
        end
    endtask
endmodule // snc_far_node

/* verification/test_spacewire_node_control_status.sv */
`timescale 1ns/1ps
module test_spacewire_node_control_status;
    reg         clock;
    reg         reset;
    reg         reg_sel;
    reg         reg_write;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata;
    reg         run;
    reg  [31:0] rd;
    wire [6:0]  ev;
    wire        link_clock;
    wire [31:0] reg_rdata;
    wire [5:0]  time_counter;
    wire [2:0]  link_state;
    wire        codec_shutoff;
    wire        node_soft_clear;
    wire        timecode_send_pulse;
    wire        irq;
    wire [4:0]  ctl_lv;
    wire        lclk_edge;
    integer     num_errors, comparisons, irq_cnt, send_cnt, i, ctl_m, edge_cnt;
    snc_node_regs #(.INSTANCE(2'd2)) dut (.clock(clock), .reset(reset), .reg_sel(reg_sel),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .early_end_event(ev[0]), .bad_destination_event(ev[1]), .write_sync_event(ev[2]),
        .link_error_event(ev[3]), .timecode_valid_event(ev[4]), .char_done(ev[5]), .null_received(ev[6]),
        .link_clock(link_clock), .remote_handler_on(ctl_lv[3]), .remote_single_buffer(ctl_lv[4]),
        .timecode_accept_on(ctl_lv[2]), .timecode_send_on(ctl_lv[1]), .open_packet_mode(ctl_lv[0]),
        .codec_shutoff(codec_shutoff), .node_soft_clear(node_soft_clear),
        .timecode_send_pulse(timecode_send_pulse), .time_counter(time_counter), .link_state(link_state),
        .link_clock_edge(lclk_edge), .irq(irq));
    snc_far_node far (.run(run), .ev(ev), .link_clock(link_clock));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (timecode_send_pulse === 1'b1) send_cnt <= send_cnt + 1;
        if (lclk_edge === 1'b1) edge_cnt <= edge_cnt + 1;
    end
    task check(input [31:0] got, input [31:0] exp, input [31:0] mask);
        begin
            comparisons = comparisons + 1;
            if ((got & mask) !== (exp & mask)) begin
                num_errors = num_errors + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock);
            reg_sel <= 1'b1;
            reg_write <= w;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clock);
            reg_sel <= 1'b0;
            #1 rd = reg_rdata;
        end
    endtask
    // Control model: writable bits follow the write, capability bits are fixed for instance 2.
    task wctl(input [31:0] d);
        begin
            bus(1'b1, 8'h00, d);
            ctl_m = (d & 32'h00030f2e) | 32'ha0000000;
        end
    endtask
    task rctl(input [31:0] mask);
        begin
            bus(1'b0, 8'h00, 32'h0);
            check(rd, ctl_m, mask);
            check({27'h0, ctl_lv}, {27'h0, ctl_m[17], ctl_m[16], ctl_m[11], ctl_m[10], ctl_m[5]}, 32'h1f);
        end
    endtask
    task wait_state(input [2:0] s);
        begin
            for (i = 0; i < 500 && link_state !== s; i = i + 1) @(posedge clock);
            check({29'h0, link_state}, {29'h0, s}, 32'h7);
        end
    endtask
    task final_report;
        begin
            if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        num_errors = num_errors + 1;
        final_report;
    end
    initial begin
        reset = 1'b1; reg_sel = 1'b0; reg_write = 1'b0; reg_addr = 8'h0; reg_wdata = 32'h0; run = 1'b0;
        num_errors = 0; comparisons = 0; irq_cnt = 0; send_cnt = 0; edge_cnt = 0;
        ctl_m = 32'ha0000002;
        i = $urandom(66);
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rctl(32'hfffffcfb);
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0, 32'hff1fffc0);
        bus(1'b1, 8'h08, 32'hffffffff);
        bus(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0, 32'hffffffff);
        rctl(32'hfffffcfb);
        repeat (8) begin
            wctl($urandom & 32'hffffffae);
            rctl(32'hffffffff);
        end
        wctl(32'h2);
        run <= 1'b1;
        wait_state(3'h3);
        far.pulse(6);
        far.pulse(6);
        wait_state(3'h5);
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h00a00000, 32'h00e00000);
        check({31'h0, edge_cnt != 0}, 32'h1, 32'h1);
        wctl(32'h20a);
        far.pulse(3);
        check(irq_cnt, 1, 32'hffffffff);
        wctl(32'h202);
        far.pulse(3);
        check(irq_cnt, 1, 32'hffffffff);
        wctl(32'h0);
        far.pulse(3);
        wait_state(3'h2);
        repeat (20) @(posedge clock);
        check({29'h0, link_state}, 32'h2, 32'h7);
        wctl(32'h4);
        far.pulse(6);
        far.pulse(6);
        wait_state(3'h5);
        wctl(32'h90a);
        far.pulse(4);
        check(irq_cnt, 2, 32'hffffffff);
        wctl(32'h10a);
        far.pulse(4);
        check(irq_cnt, 2, 32'hffffffff);
        wctl(32'h400);
        wctl(32'h410);
        check({26'h0, time_counter}, 32'h1, 32'h3f);
        far.pulse(5);
        check(send_cnt, 1, 32'hffffffff);
        wctl(32'h0);
        wctl(32'h10);
        check({26'h0, time_counter}, 32'h1, 32'h3f);
        for (ctl_m = 0; ctl_m < 3; ctl_m = ctl_m + 1) begin
            far.pulse(ctl_m);
            bus(1'b1, 8'h04, 32'h0);
            bus(1'b0, 8'h04, 32'h0);
            check(rd, 32'h100 >> ctl_m, 32'h1c0);
            bus(1'b1, 8'h04, 32'h100 >> ctl_m);
            bus(1'b0, 8'h04, 32'h0);
            check(rd, 32'h0, 32'h1c0);
        end
        far.pulse(0);
        bus(1'b1, 8'h00, 32'h00000844);
        ctl_m = 32'ha0000006;
        repeat (6) @(posedge clock);
        rctl(32'hffffffff);
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0, 32'h1c0);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h00, 32'h0);
        repeat (3) @(posedge clock);
        check({31'h0, codec_shutoff}, 32'h1, 32'h1);
        check({29'h0, link_state}, 32'h0, 32'h7);
        final_report;
    end
endmodule // test_spacewire_node_control_status
